//--- common/plc_consts.svh
// constants of the user data memory and the routine call unit
// assumes: included by plc_pkg and by the design files, by bare name
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH

// ************************************************************
// routine call unit
// ************************************************************
`define ROUTINE_COUNT   256
`define ROUTINE_NUM_MAX 9'h0ff
`define NEST_DEPTH      3'h6
`define DEPTH_RESET     3'h0
`define PC_RESET        16'h0000
`define PC_STEP         16'h0001

// ************************************************************
// user data memory: word width, last legal address per area
// ************************************************************
`define WORD_BITS       16
`define MEM_WORDS       19712
`define XIO_LAST        14'h00ff
`define SW_LAST         14'h00ff
`define RW_LAST         14'h01ff
`define TC_LAST         14'h01ff
`define LW_LAST         14'h00ff
`define W_LAST          14'h03ff
`define W_BIT_LAST      14'h01ff
`define DF_LAST         14'h1fff

// ************************************************************
// linear base of each area inside the storage array
// ************************************************************
`define XIO_BASE        15'h0000
`define SW_BASE         15'h0100
`define RW_BASE         15'h0200
`define T_BASE          15'h0400
`define C_BASE          15'h0600
`define LW_BASE         15'h0800
`define W_BASE          15'h0900
`define D_BASE          15'h0d00
`define F_BASE          15'h2d00

`endif

//--- common/plc_pkg.sv
// types shared by the call unit, the address decoder and the call stack
// assumes: plc_consts.svh is on the include path
`include "plc_consts.svh"

package plc_pkg;

	// ************************************************************
	// function types of user data
	// ************************************************************
	typedef enum logic [3:0] {
		ft_ext_input_words, ft_plain_output_words, ft_immediate_input_words,
		ft_immediate_output_words, ft_system_flag_words, ft_aux_words,
		ft_timer_words, ft_counter_words, ft_data_words, ft_link_words,
		ft_remote_io_link_words, ft_file_words
	} ftype_e;

	typedef enum logic [1:0] {op_none, op_routine_entry_marker, op_call, op_routine_exit} call_op_e;

	// the caller kind is carried for tracing only; every kind may call
	typedef enum logic [1:0] {src_main, src_sub, src_intr, src_routine} src_e;

	typedef enum logic [2:0] {
		err_none, err_bad_num, err_undef, err_overflow,
		err_underflow, err_bad_addr, err_no_bit
	} err_e;

	typedef logic [`WORD_BITS-1:0] word_t;

	typedef struct packed {
		call_op_e    op;
		logic [8:0]  num;
		logic [15:0] pc;
		src_e        src;
	} call_cmd_s;

	typedef struct packed {
		logic        valid;
		err_e        err;
		logic [15:0] target;
	} call_rsp_s;

	typedef struct packed {
		logic        en;
		logic        wr;
		logic        bit_mode;
		ftype_e      ftype;
		logic [15:0] bcd_addr;
		logic [3:0]  bit_pos;
		word_t       wdata;
	} mem_req_s;

	typedef struct packed {
		logic  valid;
		err_e  err;
		word_t rdata;
	} mem_rsp_s;

endpackage

//--- rtl/addr_decode.sv
// decimal word address plus function type to a linear storage index
// assumes: purely combinational, used by the top for every data request
`timescale 1ns/1ns
`default_nettype none
`include "plc_consts.svh"

module addr_decode (
	input  wire logic            mclk,
	input  wire logic            reset,
	input  wire plc_pkg::ftype_e ftype,
	input  wire logic [15:0]     bcd_addr,
	input  wire logic            bit_mode,
	output logic      [14:0]     idx,
	output logic                 addr_ok,
	output logic                 bit_ok
);
	import plc_pkg::*;

	// four decimal digits, each must be 0..9
	function automatic logic bcd_valid(input logic [15:0] b);
		bcd_valid = (b[3:0] < 4'ha) && (b[7:4] < 4'ha) && (b[11:8] < 4'ha) && (b[15:12] < 4'ha);
	endfunction

	function automatic logic [13:0] bcd_to_bin(input logic [15:0] b);
		bcd_to_bin = 14'(b[15:12]) * 14'h3e8 + 14'(b[11:8]) * 14'h064 + 14'(b[7:4]) * 14'h00a + 14'(b[3:0]);
	endfunction

	logic [13:0] word_no;
	logic [13:0] last;
	logic [14:0] base;
	logic        bit_area;

	// ************************************************************
	// range and base per function type
	// ************************************************************
	always_comb begin
		word_no  = bcd_to_bin(bcd_addr); // RULE_11
		last     = `XIO_LAST;
		base     = `XIO_BASE;
		bit_area = 1'b0;
		case (ftype) // RULE_15
			ft_ext_input_words, ft_plain_output_words,
			ft_immediate_input_words, ft_immediate_output_words: begin
				last     = `XIO_LAST; // direct words alias the i/o words
				bit_area = 1'b1;
			end
			ft_system_flag_words: begin
				last     = `SW_LAST;
				base     = `SW_BASE;
				bit_area = 1'b1;
			end
			ft_aux_words: begin
				last     = `RW_LAST;
				base     = `RW_BASE;
				bit_area = 1'b1;
			end
			ft_timer_words: begin
				last = `TC_LAST;
				base = `T_BASE;
			end
			ft_counter_words: begin
				last = `TC_LAST;
				base = `C_BASE;
			end
			ft_remote_io_link_words: begin
				last     = `LW_LAST;
				base     = `LW_BASE;
				bit_area = 1'b1;
			end
			ft_link_words: begin
				last     = `W_LAST;
				base     = `W_BASE;
				bit_area = (word_no <= `W_BIT_LAST); // RULE_14
			end
			ft_data_words: begin
				last = `DF_LAST;
				base = `D_BASE;
			end
			ft_file_words: begin
				last = `DF_LAST;
				base = `F_BASE;
			end
			default: begin
				last = 14'h0000;
				base = `XIO_BASE;
			end
		endcase
		addr_ok = bcd_valid(bcd_addr) && (word_no <= last);
		bit_ok  = bit_area;
		// out-of-range requests point at word 0 so the array is never overrun
		idx     = addr_ok ? (base + {1'b0, word_no}) : 15'h0000;
	end

	// ************************************************************
	// checks
	// ************************************************************
	link_bit_limit_a: assert property (@(posedge mclk) disable iff (reset) // RULE_14
		(ftype == ft_link_words && addr_ok && word_no > `W_BIT_LAST) |-> !bit_ok)
		else $error("bit access allowed above the link bit area");

	range_limit_a: assert property (@(posedge mclk) disable iff (reset) // RULE_15
		(ftype == ft_data_words && word_no > `DF_LAST) |-> !addr_ok)
		else $error("data word accepted beyond its last address");

	// a bit request that the area refuses
	no_bit_c: cover property (@(posedge mclk) disable iff (reset) bit_mode && addr_ok && !bit_ok);

endmodule // addr_decode

`default_nettype wire

//--- rtl/call_stack.sv
// return-address stack for nested routine calls, six entries deep
// assumes: caller never asks push and pop together, pushes only when not full
`timescale 1ns/1ns
`default_nettype none
`include "plc_consts.svh"

module call_stack (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        push,
	input  wire logic        pop,
	input  wire logic [15:0] push_pc,
	output logic      [15:0] top_pc,
	output logic      [2:0]  depth,
	output logic             full,
	output logic             empty
);
	import plc_pkg::*;

	logic [15:0] slot_r   [0:5];
	logic [15:0] slot_nxt [0:5];
	logic [2:0]  depth_r;
	logic [2:0]  depth_nxt;

	// ************************************************************
	// next stack contents
	// ************************************************************
	always_comb begin
		slot_nxt  = slot_r;
		depth_nxt = depth_r;
		if (push && (depth_r != `NEST_DEPTH)) begin // RULE_17
			slot_nxt[depth_r] = push_pc;
			depth_nxt         = depth_r + 3'h1;
		end else if (pop && (depth_r != `DEPTH_RESET)) begin
			depth_nxt = depth_r - 3'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			depth_r <= `DEPTH_RESET;
			for (int i = 0; i < 6; i++) begin
				slot_r[i] <= `PC_RESET;
			end
		end else begin
			depth_r <= depth_nxt;
			slot_r  <= slot_nxt;
		end
	end

	assign depth  = depth_r;
	assign full   = (depth_r == `NEST_DEPTH); // RULE_08
	assign empty  = (depth_r == `DEPTH_RESET);
	assign top_pc = empty ? `PC_RESET : slot_r[depth_r - 3'h1];

	depth_bound_a: assert property (@(posedge mclk) disable iff (reset) depth_r <= `NEST_DEPTH) // RULE_08
		else $error("nesting depth above six");

endmodule // call_stack

`default_nettype wire

//--- rtl/plc_user_data_and_call_stack.sv
// routine call unit and user data memory of the controller core
// assumes: one command per cycle from the executing program, synchronous to mclk
//
// How it works
// RULE_01: the entry table holds up to 256 routine bodies.
// RULE_02: entry markers and calls carry a routine number and only 0..255 is accepted.
// RULE_03: a body starts at its entry marker, whose address is recorded, and ends at a return.
// RULE_04: a return carries no number and goes back by the saved context alone.
// RULE_05: a call jumps to the recorded entry of the numbered routine.
// RULE_06: a return resumes at the instruction just after the invoking call.
// RULE_07: calls are taken from main, sub, interrupt programs and from routines alike.
// RULE_08: calls nest up to six levels.
// RULE_09: the program must not call a routine that is already running; the unit does not check this and accepts such a call like any other.
// RULE_10: each data location is a sixteen bit word and counts are in words.
// RULE_11: a word is picked by function type and a decimal word address.
// RULE_12: a single bit device is one bit of its word with no storage of its own.
// RULE_13: a bit address is the word address followed by a hex bit digit.
// RULE_14: link words allow bit access in their first 512 words only.
// RULE_15: each function type has its own legal address range.
// RULE_16: a bit write changes only the addressed bit of the word.
// RULE_17: a call at full depth is refused as a program error and keeps the saved contexts.
`timescale 1ns/1ns
`default_nettype none
`include "plc_consts.svh"

module plc_user_data_and_call_stack (
	input  wire logic               mclk,
	input  wire logic               reset,
	input  wire plc_pkg::call_cmd_s call_cmd,
	output plc_pkg::call_rsp_s      call_rsp,
	output logic [2:0]              nest_depth,
	input  wire plc_pkg::mem_req_s  mem_req,
	output logic                    mem_ready,
	output plc_pkg::mem_rsp_s       mem_rsp
);
	import plc_pkg::*;

	function automatic word_t bit_mask(input logic [3:0] pos);
		bit_mask = word_t'(1) << pos;
	endfunction

	// ************************************************************
	// routine entry table
	// ************************************************************
	logic [15:0]  entry_pc [0:`ROUTINE_COUNT-1]; // RULE_01
	logic [255:0] entry_valid_r;
	logic [255:0] entry_valid_nxt;
	logic         entry_we;
	call_rsp_s    call_rsp_r;
	call_rsp_s    call_rsp_nxt;
	logic         push;
	logic         pop;
	logic [15:0]  top_pc;
	logic [2:0]   depth;
	logic         full;
	logic         empty;
	logic         num_ok;
	logic [7:0]   num8;

	call_stack u_stack (
		.mclk    (mclk),
		.reset   (reset),
		.push    (push),
		.pop     (pop),
		.push_pc (call_cmd.pc + `PC_STEP), // RULE_06
		.top_pc  (top_pc),
		.depth   (depth),
		.full    (full),
		.empty   (empty)
	);

	assign num_ok = (call_cmd.num <= `ROUTINE_NUM_MAX); // RULE_02
	assign num8   = call_cmd.num[7:0];

	// call, return and entry registration; the caller kind is not checked
	// on purpose, so every program type reaches the same path
	always_comb begin
		call_rsp_nxt    = '0;
		entry_valid_nxt = entry_valid_r;
		entry_we        = 1'b0;
		push            = 1'b0;
		pop             = 1'b0;
		case (call_cmd.op) // RULE_07
			op_routine_entry_marker: begin
				call_rsp_nxt.valid = 1'b1;
				if (!num_ok) begin
					call_rsp_nxt.err = err_bad_num; // RULE_02
				end else begin
					entry_valid_nxt[num8] = 1'b1; // RULE_03
					entry_we              = 1'b1;
					call_rsp_nxt.target   = call_cmd.pc;
				end
			end
			op_call: begin
				call_rsp_nxt.valid = 1'b1;
				if (!num_ok) begin
					call_rsp_nxt.err = err_bad_num;
				end else if (!entry_valid_r[num8]) begin
					call_rsp_nxt.err = err_undef;
				end else if (full) begin
					call_rsp_nxt.err = err_overflow; // RULE_17
				end else begin
					push                = 1'b1; // RULE_08
					call_rsp_nxt.target = entry_pc[num8]; // RULE_05
				end
			end
			op_routine_exit: begin
				call_rsp_nxt.valid = 1'b1;
				if (empty) begin
					call_rsp_nxt.err = err_underflow;
				end else begin
					pop                 = 1'b1;
					call_rsp_nxt.target = top_pc; // RULE_04
				end
			end
			default: begin
				call_rsp_nxt = '0;
			end
		endcase
	end

	// entry addresses need no reset: the valid bits guard them
	always_ff @(posedge mclk) begin
		if (entry_we) begin
			entry_pc[num8] <= call_cmd.pc;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			entry_valid_r <= '0;
			call_rsp_r    <= '0;
		end else begin
			entry_valid_r <= entry_valid_nxt;
			call_rsp_r    <= call_rsp_nxt;
		end
	end

	assign call_rsp   = call_rsp_r;
	assign nest_depth = depth;

	// ************************************************************
	// user data memory
	// ************************************************************
	typedef enum logic {mem_idle, mem_access} mem_state_e;

	word_t      data_mem [0:`MEM_WORDS-1]; // RULE_10
	word_t      mem_q;
	mem_state_e state_r;
	mem_state_e state_nxt;
	mem_req_s   req_r;
	mem_req_s   req_nxt;
	logic [14:0] idx_r;
	logic [14:0] idx_nxt;
	err_e       derr_r;
	err_e       derr_nxt;
	logic       ready_r;
	logic       ready_nxt;
	mem_rsp_s   mem_rsp_r;
	mem_rsp_s   mem_rsp_nxt;
	logic       mem_we;
	word_t      wr_word;
	logic [14:0] dec_idx;
	logic       addr_ok;
	logic       bit_ok;

	addr_decode u_decode (
		.mclk     (mclk),
		.reset    (reset),
		.ftype    (mem_req.ftype),
		.bcd_addr (mem_req.bcd_addr),
		.bit_mode (mem_req.bit_mode),
		.idx      (dec_idx),
		.addr_ok  (addr_ok),
		.bit_ok   (bit_ok)
	);

	// every access is read first, so a bit write merges into the word
	// as it stands; costs one extra cycle for plain word writes too
	always_comb begin
		state_nxt   = state_r;
		req_nxt     = req_r;
		idx_nxt     = idx_r;
		derr_nxt    = derr_r;
		ready_nxt   = ready_r;
		mem_rsp_nxt = '0;
		mem_we      = 1'b0;
		wr_word     = req_r.wdata;
		case (state_r)
			mem_idle: begin
				if (mem_req.en) begin
					req_nxt   = mem_req;
					idx_nxt   = dec_idx;
					ready_nxt = 1'b0;
					state_nxt = mem_access;
					if (!addr_ok) begin
						derr_nxt = err_bad_addr; // RULE_15
					end else if (mem_req.bit_mode && !bit_ok) begin
						derr_nxt = err_no_bit; // RULE_14
					end else begin
						derr_nxt = err_none;
					end
				end
			end
			mem_access: begin
				mem_rsp_nxt.valid = 1'b1;
				mem_rsp_nxt.err   = derr_r;
				state_nxt         = mem_idle;
				ready_nxt         = 1'b1;
				if (derr_r == err_none) begin
					if (req_r.wr) begin
						mem_we = 1'b1;
						if (req_r.bit_mode) begin
							// only the addressed bit moves
							wr_word = (mem_q & ~bit_mask(req_r.bit_pos)) | // RULE_16
							          (req_r.wdata[0] ? bit_mask(req_r.bit_pos) : '0);
						end
					end else if (req_r.bit_mode) begin
						mem_rsp_nxt.rdata = word_t'(mem_q[req_r.bit_pos]); // RULE_12 RULE_13
					end else begin
						mem_rsp_nxt.rdata = mem_q;
					end
				end
			end
			default: begin
				state_nxt = mem_idle;
				ready_nxt = 1'b1;
			end
		endcase
	end

	// storage array: holds no reset, user data survives a controller reset
	always_ff @(posedge mclk) begin
		if (mem_we) begin
			data_mem[idx_r] <= wr_word;
		end
		mem_q <= data_mem[dec_idx];
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_r   <= mem_idle;
			req_r     <= '0;
			idx_r     <= 15'h0000;
			derr_r    <= err_none;
			ready_r   <= 1'b1;
			mem_rsp_r <= '0;
		end else begin
			state_r   <= state_nxt;
			req_r     <= req_nxt;
			idx_r     <= idx_nxt;
			derr_r    <= derr_nxt;
			ready_r   <= ready_nxt;
			mem_rsp_r <= mem_rsp_nxt;
		end
	end

	assign mem_ready = ready_r;
	assign mem_rsp   = mem_rsp_r;

	// ************************************************************
	// checks
	// ************************************************************
	call_push_a: assert property (@(posedge mclk) disable iff (reset) // RULE_08
		(call_cmd.op == op_call && num_ok && entry_valid_r[num8] && !full) |=> (depth == $past(depth) + 3'h1))
		else $error("accepted call did not deepen the stack");

	overflow_keep_a: assert property (@(posedge mclk) disable iff (reset) // RULE_17
		(call_cmd.op == op_call && num_ok && entry_valid_r[num8] && full)
		|=> (call_rsp.err == err_overflow && depth == `NEST_DEPTH && top_pc == $past(top_pc)))
		else $error("call at full depth not refused cleanly");

	call_target_a: assert property (@(posedge mclk) disable iff (reset) // RULE_05
		(call_cmd.op == op_call && num_ok && entry_valid_r[num8] && !full)
		|=> (call_rsp.valid && call_rsp.err == err_none && call_rsp.target == entry_pc[$past(num8)]))
		else $error("call went to the wrong entry");

	return_site_a: assert property (@(posedge mclk) disable iff (reset) // RULE_06
		(call_cmd.op == op_call && num_ok && entry_valid_r[num8] && !full) ##1 (call_cmd.op == op_none) ##1
		(call_cmd.op == op_routine_exit) |=> (call_rsp.target == $past(call_cmd.pc, 3) + `PC_STEP))
		else $error("return did not land after its call");

	bad_number_a: assert property (@(posedge mclk) disable iff (reset) // RULE_02
		((call_cmd.op == op_call || call_cmd.op == op_routine_entry_marker) && !num_ok)
		|=> (call_rsp.valid && call_rsp.err == err_bad_num && $stable(depth)))
		else $error("routine number above 255 accepted");

	mem_latency_a: assert property (@(posedge mclk) disable iff (reset) // RULE_15
		(state_r == mem_idle && mem_req.en && !addr_ok)
		|-> ##1 !mem_ready ##1 (mem_rsp.valid && mem_rsp.err == err_bad_addr && mem_ready))
		else $error("bad address not answered in two cycles");

	bit_only_a: assert property (@(posedge mclk) disable iff (reset) // RULE_16
		(mem_we && req_r.bit_mode) |-> (((wr_word ^ mem_q) & ~bit_mask(req_r.bit_pos)) == '0))
		else $error("bit write disturbed other bits");

	bit_read_a: assert property (@(posedge mclk) disable iff (reset) // RULE_12
		(state_r == mem_access && derr_r == err_none && !req_r.wr && req_r.bit_mode)
		|=> (mem_rsp.rdata[15:1] == 15'h0000 && mem_rsp.rdata[0] == $past(mem_q[req_r.bit_pos])))
		else $error("bit read not taken from its word");

	full_nest_c: cover property (@(posedge mclk) disable iff (reset) depth == `NEST_DEPTH);
	refused_c:   cover property (@(posedge mclk) disable iff (reset) call_rsp.err == err_overflow);
	return_c:    cover property (@(posedge mclk) disable iff (reset) pop ##1 call_rsp.valid);
	bit_write_c: cover property (@(posedge mclk) disable iff (reset) mem_we && req_r.bit_mode);

endmodule // plc_user_data_and_call_stack

`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the routine call unit and user data memory
// assumes: plc_pkg compiled first; the design holds its own assertions
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import plc_pkg::*;

	// ************************************************************
	// clock, reset and design ports
	// ************************************************************
	logic      mclk = 1'b0;
	logic      reset = 1'b1;
	call_cmd_s call_cmd = '0;
	call_rsp_s call_rsp;
	logic [2:0] nest_depth;
	mem_req_s  mem_req = '0;
	logic      mem_ready;
	mem_rsp_s  mem_rsp;
	int        n_mismatch = 0;
	int        check_count = 0;

	typedef struct {
		ftype_e      ft;
		logic [15:0] a;
		logic        bm;
		logic [3:0]  bp;
		logic        wr;
		word_t       wd;
		err_e        ee;
		word_t       er;
	} row_s;
	row_s rows[$];

	// half period of 10 ns gives 50 MHz
	always #10 mclk = ~mclk;

	plc_user_data_and_call_stack dut (
		.mclk       (mclk),
		.reset      (reset),
		.call_cmd   (call_cmd),
		.call_rsp   (call_rsp),
		.nest_depth (nest_depth),
		.mem_req    (mem_req),
		.mem_ready  (mem_ready),
		.mem_rsp    (mem_rsp)
	);

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one command, then idle; the answer is looked at in its single cycle
	task automatic do_call(input call_op_e op, input logic [8:0] num, input logic [15:0] pc, input src_e src,
			input err_e ee, input logic [15:0] et, input logic [2:0] ed);
		@(posedge mclk);
		call_cmd <= '{op, num, pc, src};
		@(posedge mclk);
		call_cmd <= '{op_none, 9'h000, 16'h0000, src_main};
		#1;
		check("call valid", call_rsp.valid, 1'b1);
		check("call err", call_rsp.err, ee);
		if (ee == err_none)
			check("call target", call_rsp.target, et);
		check("nest depth", nest_depth, ed);
	endtask

	// request held until the taking edge, answer one edge after it
	task automatic do_mem(input row_s r);
		@(posedge mclk);
		mem_req <= '{1'b1, r.wr, r.bm, r.ft, r.a, r.bp, r.wd};
		@(posedge mclk);
		mem_req.en <= 1'b0;
		#1;
		check("ready low", mem_ready, 1'b0);
		@(posedge mclk);
		#1;
		check("mem valid", mem_rsp.valid, 1'b1);
		check("mem err", mem_rsp.err, r.ee);
		check("mem rdata", mem_rsp.rdata, r.er);
		check("ready back", mem_ready, 1'b1);
	endtask

	task automatic add(input ftype_e ft, input logic [15:0] a, input logic bm, input logic [3:0] bp,
			input logic wr, input word_t wd, input err_e ee, input word_t er);
		rows.push_back('{ft, a, bm, bp, wr, wd, ee, er});
	endtask

	// ************************************************************
	// watchdog: the whole run needs well under 1000 cycles
	// ************************************************************
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		#1;
		check("reset depth", nest_depth, 3'h0);
		check("reset rsp", call_rsp.valid, 1'b0);
		check("reset ready", mem_ready, 1'b1);
		check("reset mrsp", mem_rsp.valid, 1'b0);

		// data memory rows: word, bit, alias and range cases
		add(ft_aux_words, 16'h0100, 1'b0, 4'h0, 1'b1, 16'h1234, err_none, 16'h0000);
		add(ft_aux_words, 16'h0100, 1'b1, 4'h6, 1'b1, 16'h0001, err_none, 16'h0000);
		add(ft_aux_words, 16'h0100, 1'b1, 4'h2, 1'b1, 16'h0000, err_none, 16'h0000);
		add(ft_aux_words, 16'h0100, 1'b0, 4'h0, 1'b0, 16'h0000, err_none, 16'h1270);
		add(ft_aux_words, 16'h0100, 1'b1, 4'h6, 1'b0, 16'h0000, err_none, 16'h0001);
		add(ft_ext_input_words, 16'h0005, 1'b0, 4'h0, 1'b1, 16'h0064, err_none, 16'h0000);
		add(ft_immediate_input_words, 16'h0005, 1'b0, 4'h0, 1'b0, 16'h0000, err_none, 16'h0064);
		add(ft_ext_input_words, 16'h0005, 1'b1, 4'h6, 1'b0, 16'h0000, err_none, 16'h0001);
		add(ft_data_words, 16'h0000, 1'b0, 4'h0, 1'b1, 16'h00d0, err_none, 16'h0000);
		add(ft_file_words, 16'h0000, 1'b0, 4'h0, 1'b1, 16'h00f0, err_none, 16'h0000);
		add(ft_data_words, 16'h0000, 1'b0, 4'h0, 1'b0, 16'h0000, err_none, 16'h00d0);
		add(ft_data_words, 16'h8191, 1'b0, 4'h0, 1'b1, 16'hbeef, err_none, 16'h0000);
		add(ft_data_words, 16'h8192, 1'b0, 4'h0, 1'b1, 16'h0001, err_bad_addr, 16'h0000);
		add(ft_file_words, 16'h8191, 1'b0, 4'h0, 1'b1, 16'h5555, err_none, 16'h0000);
		add(ft_file_words, 16'h8191, 1'b0, 4'h0, 1'b0, 16'h0000, err_none, 16'h5555);
		add(ft_plain_output_words, 16'h0256, 1'b0, 4'h0, 1'b0, 16'h0000, err_bad_addr, 16'h0000);
		add(ft_system_flag_words, 16'h0255, 1'b0, 4'h0, 1'b1, 16'h0000, err_none, 16'h0000);
		add(ft_system_flag_words, 16'h0255, 1'b1, 4'hf, 1'b1, 16'h0001, err_none, 16'h0000);
		add(ft_system_flag_words, 16'h0255, 1'b0, 4'h0, 1'b0, 16'h0000, err_none, 16'h8000);
		add(ft_aux_words, 16'h0512, 1'b0, 4'h0, 1'b0, 16'h0000, err_bad_addr, 16'h0000);
		add(ft_timer_words, 16'h0511, 1'b0, 4'h0, 1'b1, 16'h0123, err_none, 16'h0000);
		add(ft_counter_words, 16'h0512, 1'b0, 4'h0, 1'b0, 16'h0000, err_bad_addr, 16'h0000);
		add(ft_remote_io_link_words, 16'h0256, 1'b0, 4'h0, 1'b0, 16'h0000, err_bad_addr, 16'h0000);
		add(ft_link_words, 16'h1024, 1'b0, 4'h0, 1'b0, 16'h0000, err_bad_addr, 16'h0000);
		add(ft_aux_words, 16'h00a0, 1'b0, 4'h0, 1'b0, 16'h0000, err_bad_addr, 16'h0000);
		add(ft_timer_words, 16'h0511, 1'b1, 4'h0, 1'b0, 16'h0000, err_no_bit, 16'h0000);
		add(ft_data_words, 16'h0000, 1'b1, 4'h0, 1'b1, 16'h0001, err_no_bit, 16'h0000);
		add(ft_link_words, 16'h0512, 1'b0, 4'h0, 1'b1, 16'haaaa, err_none, 16'h0000);
		add(ft_link_words, 16'h0512, 1'b1, 4'h0, 1'b1, 16'h0000, err_no_bit, 16'h0000);
		add(ft_link_words, 16'h0512, 1'b0, 4'h0, 1'b0, 16'h0000, err_none, 16'haaaa);
		add(ft_link_words, 16'h0511, 1'b0, 4'h0, 1'b1, 16'h00f0, err_none, 16'h0000);
		add(ft_link_words, 16'h0511, 1'b1, 4'h3, 1'b1, 16'h0001, err_none, 16'h0000);
		add(ft_link_words, 16'h0511, 1'b1, 4'h3, 1'b0, 16'h0000, err_none, 16'h0001);
		add(ft_link_words, 16'h0511, 1'b0, 4'h0, 1'b0, 16'h0000, err_none, 16'h00f8);
		foreach (rows[i])
			do_mem(rows[i]);

		// routine entries 0..6 and 255, then an out-of-range number
		for (int n = 0; n < 7; n++)
			do_call(op_routine_entry_marker, 9'(n), 16'h1000 + 16'(n * 16), src_main, err_none,
				16'h1000 + 16'(n * 16), 3'h0);
		do_call(op_routine_entry_marker, 9'h0ff, 16'h2ff0, src_main, err_none, 16'h2ff0, 3'h0);
		do_call(op_routine_entry_marker, 9'h100, 16'h3000, src_main, err_bad_num, 16'h0000, 3'h0);
		do_call(op_call, 9'h100, 16'h0040, src_main, err_bad_num, 16'h0000, 3'h0);
		do_call(op_call, 9'h007 + 9'h001, 16'h0040, src_main, err_undef, 16'h0000, 3'h0);

		// six nested calls from every caller kind, a seventh refused
		for (int n = 0; n < 6; n++)
			do_call(op_call, 9'(n), 16'h0200 + 16'(n * 2), src_e'(n % 4), err_none,
				16'h1000 + 16'(n * 16), 3'(n + 1));
		do_call(op_call, 9'h006, 16'h0300, src_routine, err_overflow, 16'h0000, 3'h6);
		for (int n = 5; n >= 0; n--)
			do_call(op_routine_exit, 9'h000, 16'h0000, src_main, err_none, 16'h0201 + 16'(n * 2), 3'(n));
		do_call(op_routine_exit, 9'h000, 16'h0000, src_main, err_underflow, 16'h0000, 3'h0);
		do_call(op_call, 9'h0ff, 16'h0500, src_intr, err_none, 16'h2ff0, 3'h1);
		do_call(op_routine_exit, 9'h0ff, 16'h0000, src_main, err_none, 16'h0501, 3'h0);

		// reset in mid-run clears the nesting depth
		do_call(op_call, 9'h001, 16'h0600, src_sub, err_none, 16'h1010, 3'h1);
		@(posedge mclk);
		reset <= 1'b1;
		@(posedge mclk);
		reset <= 1'b0;
		#1;
		check("second reset depth", nest_depth, 3'h0);
		do_call(op_call, 9'h001, 16'h0600, src_main, err_undef, 16'h0000, 3'h0);
		stop_test();
	end
endmodule // testbench

`default_nettype wire
